//--- inc/rcs_pkg.sv
`default_nettype none
package rcs_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ = 20_000_000;
    localparam int BAUD_RATE = 2400;
    localparam int REPORT_MS = 2000;
    // rounds down to 8333; the error is far inside serial tolerance
    localparam int BAUD_CYCLES = CLK_HZ / BAUD_RATE;
    localparam int REPORT_CYCLES = (CLK_HZ / 1000) * REPORT_MS;

    // ****************************************
    // serial frame and report layout
    // ****************************************
    localparam int DATA_BITS = 8;
    localparam int FRAME_BITS = DATA_BITS + 2;
    localparam int NUM_ALARMS = 2;
    localparam int LINE_MAX = 16;
    localparam logic [2:0] LAST_ITEM = 3'(2 + 2 * NUM_ALARMS);
    localparam logic [7:0] CHR_CR = 8'h0D;
    localparam logic [7:0] CHR_LF = 8'h0A;
    localparam logic [7:0] CHR_ZERO = 8'h30;
    localparam logic [7:0] CHR_SPACE = 8'h20;
    localparam logic [7:0] CHR_DASH = 8'h2D;

    // ****************************************
    // commands and reset values
    // ****************************************
    localparam logic [15:0] CMD_SPAN = 16'h6173;
    localparam logic [15:0] CMD_ZERO = 16'h617A;
    localparam logic [15:0] CMD_PAUSE = 16'h7374;
    localparam logic [1:0] CMD_LEN = 2'h2;
    localparam logic [1:0] CMD_OVER = 2'h3;
    localparam logic [3:0] RELAY_RESET = 4'h1;

    typedef enum logic [1:0] {RNG_LO, RNG_MED, RNG_HI, RNG_AIR} rcs_range_e;
    typedef enum logic [1:0] {CAL_ANALYZE, CAL_ZERO, CAL_SPAN} rcs_cal_e;
    typedef enum logic {GEN_IDLE, GEN_RUN} rcs_gen_e;

    typedef struct packed {
        logic sample;
        logic zero;
        logic span;
        logic exhaust;
    } rcs_valve_s;

    localparam rcs_valve_s VALVE_RESET = '{sample: 1'b1, zero: 1'b0, span: 1'b0, exhaust: 1'b0};

    typedef struct packed {
        logic [15:0] concBcd;
        logic unitPct;
        logic [11:0] spanBcd;
        logic [NUM_ALARMS-1:0] alarmOff;
        logic [NUM_ALARMS-1:0] alarmTrip;
    } rcs_status_s;

    typedef struct packed {
        logic [0:LINE_MAX-1][7:0] txt;
        logic [4:0] len;
    } rcs_line_s;
endpackage
`default_nettype wire

//--- core/rcs_buf2.sv
`timescale 1ns/100ps
`default_nettype none
module rcs_buf2
    import rcs_pkg::*;
#(
    parameter int WIDTH = DATA_BITS
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam logic [1:0] FULL = 2'h2;
    logic [WIDTH-1:0] mem_reg [2];
    logic wrPtr_reg;
    logic rdPtr_reg;
    logic [1:0] count_reg;
    logic push;
    logic pop;

    // ****************************************
    // two-entry queue
    // ****************************************
    assign inReady = count_reg != FULL;
    assign outValid = count_reg != 2'h0;
    assign outData = mem_reg[rdPtr_reg];
    assign push = inValid && inReady && clkEn;
    assign pop = outValid && outReady && clkEn;

    // data words carry no reset, only the pointers and the count do
    always_ff @(posedge clock) begin
        if (push) begin
            mem_reg[wrPtr_reg] <= inData;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wrPtr_reg <= 1'b0;
            rdPtr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            if (push) begin
                wrPtr_reg <= ~wrPtr_reg;
            end
            if (pop) begin
                rdPtr_reg <= ~rdPtr_reg;
            end
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule
`default_nettype wire

//--- core/rcs_uart.sv
`timescale 1ns/100ps
`default_nettype none
module rcs_uart
    import rcs_pkg::*;
#(
    parameter int DIV = BAUD_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic [7:0] txData,
    input wire logic txValid,
    output logic txReady,
    output logic txd,
    input wire logic rxd,
    output logic [7:0] rxData,
    output logic rxValid
);
    localparam int CW = $clog2(DIV + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(DIV - 1);
    localparam logic [CW-1:0] CNT_HALF = CW'(DIV / 2);
    localparam logic [3:0] NBITS = 4'(FRAME_BITS);
    logic [9:0] txShift_reg;
    logic [3:0] txBits_reg;
    logic [CW-1:0] txCnt_reg;
    logic [7:0] rxShift_reg;
    logic [3:0] rxBits_reg;
    logic [CW-1:0] rxCnt_reg;

    // ****************************************
    // transmitter, 8N1
    // ****************************************
    assign txReady = txBits_reg == 4'h0;

    // two trailing ones keep the line high after the stop bit
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            txd <= 1'b1;
            txShift_reg <= 10'h3FF;
            txBits_reg <= 4'h0;
            txCnt_reg <= '0;
        end else if (clkEn) begin
            if (txBits_reg == 4'h0) begin
                if (txValid) begin
                    txd <= 1'b0;
                    txShift_reg <= {2'h3, txData};
                    txBits_reg <= NBITS;
                    txCnt_reg <= CNT_LAST;
                end
            end else if (txCnt_reg == '0) begin
                txd <= txShift_reg[0];
                txShift_reg <= {1'b1, txShift_reg[9:1]};
                txBits_reg <= txBits_reg - 4'h1;
                txCnt_reg <= CNT_LAST;
            end else begin
                txCnt_reg <= txCnt_reg - 1'b1;
            end
        end
    end

    // ****************************************
    // receiver, runs beside the transmitter
    // ****************************************
    // samples mid-bit; a start bit gone high again is a glitch
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rxBits_reg <= 4'h0;
            rxCnt_reg <= '0;
            rxShift_reg <= 8'h00;
            rxData <= 8'h00;
            rxValid <= 1'b0;
        end else if (clkEn) begin
            rxValid <= 1'b0;
            if (rxBits_reg == 4'h0) begin
                if (!rxd) begin
                    rxBits_reg <= NBITS;
                    rxCnt_reg <= CNT_HALF;
                end
            end else if (rxCnt_reg == '0) begin
                rxCnt_reg <= CNT_LAST;
                rxBits_reg <= rxBits_reg - 4'h1;
                if (rxBits_reg == NBITS && rxd) begin
                    rxBits_reg <= 4'h0;
                end else if (rxBits_reg == 4'h1) begin
                    rxValid <= rxd;
                    rxData <= rxShift_reg;
                end else if (rxBits_reg != NBITS) begin
                    rxShift_reg <= {rxd, rxShift_reg[7:1]};
                end
            end else begin
                rxCnt_reg <= rxCnt_reg - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- core/rcs_port.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// R1: controller checks busy contact open, then holds zero request until it closes.
// R2: controller drops zero request once the busy contact closes.
// R3: after reopen, controller holds span request until contact closes, then drops it.
// R4: busy contact reopens when calibration ends; back to analysing.
// R5: exactly one of four range relays on: low, medium, high, air-cal.
// R6: sample, zero, span and exhaust valve outputs follow the calibration mode.
// R7: a status report goes out every 2 seconds while reports are enabled.
// R8: report order: concentration, range, span, disabled alarms, tripped alarms.
// R9: every report item ends with carriage return then line feed.
// R10: alarm items name the alarm number, tagged DISABLED or ON.
// R11: autospan command plus enter starts span calibration at once.
// R12: autozero command plus enter starts zero calibration at once.
// R13: each pause-toggle command plus enter stops or restarts periodic reports.
// R14: serial link runs 2400 baud, 8 data bits, no parity, 1 stop bit.
// R15: reception runs fully independent of and concurrent with transmission.
// R16: busy contact stays closed through the whole zero or span calibration.
// R17: requests during calibration are ignored, not stored; sampled only while analysing.
// R18: a request still held when calibration ends runs it again.
// R19: collect characters to carriage return; run only the three commands, drop others.
// R20: a new report starts only after the previous one is fully handed to the two-entry byte queue; up to 3 of its bytes may still be unsent.
module rcs_port
    import rcs_pkg::*;
#(
    parameter int BAUD_DIV = BAUD_CYCLES,
    parameter int REPORT_DIV = REPORT_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic zeroReq,
    input wire logic spanReq,
    input wire logic calDone,
    input wire logic [1:0] rangeSel,
    input wire rcs_status_s status,
    input wire logic rxd,
    output logic txd,
    output logic calBusy,
    output logic [3:0] rangeRelay,
    output rcs_valve_s valves
);
    localparam int RW = $clog2(REPORT_DIV + 1);
    localparam logic [RW-1:0] REP_LAST = RW'(REPORT_DIV - 1);

    rcs_cal_e calState_reg;
    rcs_cal_e calNext;
    logic calBusy_reg;
    rcs_valve_s valves_reg;
    logic [3:0] rangeRelay_reg;
    logic [15:0] rxChars_reg;
    logic [1:0] rxCount_reg;
    logic cmdZero_reg;
    logic cmdSpan_reg;
    logic cmdPause_reg;
    logic reportEn_reg;
    logic [RW-1:0] repCnt_reg;
    logic tickPending_reg;
    rcs_gen_e genState_reg;
    logic [2:0] genItem_reg;
    logic [4:0] genIdx_reg;
    rcs_status_s snap_reg;
    rcs_range_e rangeSnap_reg;
    rcs_line_s curLine;
    logic pushValid;
    logic [7:0] pushData;
    logic bufInReady;
    logic [7:0] bufData;
    logic bufValid;
    logic txReady;
    logic [7:0] rxData;
    logic rxValid;
    logic prevCr_reg;

    assign calBusy = calBusy_reg;
    assign valves = valves_reg;
    assign rangeRelay = rangeRelay_reg;

    // ****************************************
    // calibration sequencing
    // ****************************************
    // requests are looked at only in analyse, so nothing is queued
    always_comb begin
        calNext = calState_reg;
        unique case (calState_reg)
            CAL_ANALYZE: begin
                if (zeroReq || cmdZero_reg) begin
                    calNext = CAL_ZERO; // see R12 see R17 see R18
                end else if (spanReq || cmdSpan_reg) begin
                    calNext = CAL_SPAN; // see R11
                end
            end
            CAL_ZERO, CAL_SPAN: begin
                if (calDone) begin
                    calNext = CAL_ANALYZE; // see R4
                end
            end
            default: calNext = CAL_ANALYZE;
        endcase
    end

    // contact and valves follow the next state so they stay in step
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            calState_reg <= CAL_ANALYZE;
            calBusy_reg <= 1'b0;
            valves_reg <= VALVE_RESET;
        end else if (clkEn) begin
            calState_reg <= calNext;
            calBusy_reg <= calNext != CAL_ANALYZE; // see R16
            valves_reg.sample <= calNext == CAL_ANALYZE; // see R6
            valves_reg.zero <= calNext == CAL_ZERO;
            valves_reg.span <= calNext == CAL_SPAN;
            valves_reg.exhaust <= calNext != CAL_ANALYZE;
        end
    end

    // ****************************************
    // range indicator relays
    // ****************************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rangeRelay_reg <= RELAY_RESET;
        end else if (clkEn) begin
            rangeRelay_reg <= RELAY_RESET << rangeSel; // see R5
        end
    end

    // ****************************************
    // command line parser
    // ****************************************
    // an overlong line saturates the count and is dropped at enter
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rxChars_reg <= 16'h0000;
            rxCount_reg <= 2'h0;
            cmdZero_reg <= 1'b0;
            cmdSpan_reg <= 1'b0;
            cmdPause_reg <= 1'b0;
        end else if (clkEn) begin
            cmdZero_reg <= 1'b0;
            cmdSpan_reg <= 1'b0;
            cmdPause_reg <= 1'b0;
            if (rxValid) begin
                if (rxData == CHR_CR) begin
                    rxCount_reg <= 2'h0;
                    if (rxCount_reg == CMD_LEN) begin // see R19
                        cmdZero_reg <= rxChars_reg == CMD_ZERO;
                        cmdSpan_reg <= rxChars_reg == CMD_SPAN;
                        cmdPause_reg <= rxChars_reg == CMD_PAUSE;
                    end
                end else if (rxData != CHR_LF) begin
                    rxChars_reg <= {rxChars_reg[7:0], rxData};
                    if (rxCount_reg != CMD_OVER) begin
                        rxCount_reg <= rxCount_reg + 2'h1;
                    end
                end
            end
        end
    end

    // ****************************************
    // report timer and pause
    // ****************************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reportEn_reg <= 1'b1;
        end else if (clkEn && cmdPause_reg) begin
            reportEn_reg <= ~reportEn_reg; // see R13
        end
    end

    // a pending tick waits for the generator; pause drops it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            repCnt_reg <= '0;
            tickPending_reg <= 1'b0;
        end else if (clkEn) begin
            if (!reportEn_reg || genState_reg == GEN_IDLE) begin
                tickPending_reg <= 1'b0;
            end
            if (repCnt_reg == REP_LAST) begin
                repCnt_reg <= '0;
                if (reportEn_reg) begin
                    tickPending_reg <= 1'b1; // see R7
                end
            end else begin
                repCnt_reg <= repCnt_reg + 1'b1;
            end
        end
    end

    // ****************************************
    // report text
    // ****************************************
    function automatic rcs_line_s lineOf(input logic [2:0] item, input rcs_status_s s, input rcs_range_e r);
        rcs_line_s l;
        int n;
        int a;
        l = '0;
        n = 0;
        a = int'(item) - 3;
        if (item == 3'h0) begin
            for (int i = 0; i < 4; i++) begin
                l.txt[i] = CHR_ZERO + {4'h0, s.concBcd[15-4*i -: 4]};
            end
            l.txt[4] = CHR_SPACE;
            if (s.unitPct) begin
                l.txt[5] = "%";
                n = 6;
            end else begin
                l.txt[5:7] = "PPM";
                n = 8;
            end
        end else if (item == 3'h1) begin
            unique case (r)
                RNG_LO: begin l.txt[0:1] = "LO"; n = 2; end
                RNG_MED: begin l.txt[0:2] = "MED"; n = 3; end
                RNG_HI: begin l.txt[0:1] = "HI"; n = 2; end
                RNG_AIR: begin l.txt[0:2] = "AIR"; n = 3; end
            endcase
        end else if (item == 3'h2) begin
            l.txt[0] = CHR_ZERO;
            l.txt[1] = CHR_DASH;
            for (int i = 0; i < 3; i++) begin
                l.txt[2+i] = CHR_ZERO + {4'h0, s.spanBcd[11-4*i -: 4]};
            end
            n = 5;
        end else if (a < NUM_ALARMS ? s.alarmOff[a] : s.alarmTrip[a-NUM_ALARMS]) begin
            // see R10
            l.txt[0:2] = "AL-";
            l.txt[3] = CHR_ZERO + 8'(a % NUM_ALARMS + 1);
            if (a < NUM_ALARMS) begin
                l.txt[4:12] = " DISABLED";
                n = 13;
            end else begin
                l.txt[4:6] = " ON";
                n = 7;
            end
        end
        if (n != 0) begin
            l.txt[n] = CHR_CR; // see R9
            l.txt[n+1] = CHR_LF;
            l.len = 5'(n + 2);
        end
        return l;
    endfunction

    // item order fixed by the item counter
    always_comb begin
        curLine = lineOf(genItem_reg, snap_reg, rangeSnap_reg); // see R8
        pushValid = genState_reg == GEN_RUN && genIdx_reg < curLine.len;
        pushData = curLine.txt[genIdx_reg[3:0]];
    end

    // snapshot at start keeps one report self-consistent
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            genState_reg <= GEN_IDLE;
            genItem_reg <= 3'h0;
            genIdx_reg <= 5'h00;
            snap_reg <= '0;
            rangeSnap_reg <= RNG_LO;
        end else if (clkEn) begin
            unique case (genState_reg)
                GEN_IDLE: begin
                    if (tickPending_reg) begin // see R20
                        genState_reg <= GEN_RUN;
                        genItem_reg <= 3'h0;
                        genIdx_reg <= 5'h00;
                        snap_reg <= status;
                        rangeSnap_reg <= rcs_range_e'(rangeSel);
                    end
                end
                GEN_RUN: begin
                    if (pushValid) begin
                        if (bufInReady) begin
                            genIdx_reg <= genIdx_reg + 5'h01;
                        end
                    end else if (genItem_reg == LAST_ITEM) begin
                        genState_reg <= GEN_IDLE;
                    end else begin
                        genItem_reg <= genItem_reg + 3'h1;
                        genIdx_reg <= 5'h00;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // byte path and serial port
    // ****************************************
    rcs_buf2 #(.WIDTH(DATA_BITS)) u_buf (
        .clock(clock),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .inData(pushData),
        .inValid(pushValid),
        .inReady(bufInReady),
        .outData(bufData),
        .outValid(bufValid),
        .outReady(txReady)
    );

    // see R14 see R15
    rcs_uart #(.DIV(BAUD_DIV)) u_uart (
        .clock(clock),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .txData(bufData),
        .txValid(bufValid),
        .txReady(txReady),
        .txd(txd),
        .rxd(rxd),
        .rxData(rxData),
        .rxValid(rxValid)
    );

    // ****************************************
    // checks
    // ****************************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prevCr_reg <= 1'b0;
        end else if (clkEn && pushValid && bufInReady) begin
            prevCr_reg <= pushData == CHR_CR;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_BUSY_OPEN_AFTER_DONE: assert property ((calState_reg != CAL_ANALYZE && calDone && clkEn) |=> !calBusy_reg) // see R4
        else $error("busy contact did not reopen after calibration end");
    AST_ONE_RELAY: assert property ($onehot(rangeRelay_reg)) // see R5
        else $error("range relays not one-hot");
    AST_RELAY_FOLLOWS: assert property (clkEn |=> rangeRelay_reg == (RELAY_RESET << $past(rangeSel))) // see R5
        else $error("range relay does not match selected range");
    AST_VALVES_CAL: assert property (calBusy_reg |-> (valves_reg.zero ^ valves_reg.span) && !valves_reg.sample) // see R6
        else $error("valve outputs wrong during calibration");
    AST_BUSY_HOLDS: assert property ((calBusy_reg && !calDone) |=> calBusy_reg) // see R16
        else $error("busy contact opened before calibration ended");
    AST_NO_SWITCH: assert property ((calState_reg == CAL_ZERO && !calDone) |=> calState_reg != CAL_SPAN) // see R17
        else $error("span request taken during zero calibration");
    AST_REPEAT: assert property (($past(calBusy_reg) && !calBusy_reg && (zeroReq || spanReq) && clkEn) |=> calBusy_reg) // see R18
        else $error("held request did not rerun calibration");
    AST_CMD_ZERO: assert property ((cmdZero_reg && clkEn && calState_reg == CAL_ANALYZE) |=> valves_reg.zero) // see R12
        else $error("autozero command did not start zero");
    AST_PAUSE: assert property ((cmdPause_reg && clkEn) |=> reportEn_reg != $past(reportEn_reg)) // see R13
        else $error("pause command did not toggle reports");
    AST_PERIOD: assert property ((repCnt_reg == REP_LAST && reportEn_reg && clkEn) |=> tickPending_reg) // see R7
        else $error("report tick lost");
    AST_CRLF: assert property ((clkEn && pushValid && bufInReady && prevCr_reg) |-> pushData == CHR_LF) // see R9
        else $error("carriage return not followed by line feed");
    AST_NO_INTERLEAVE: assert property ((genState_reg == GEN_RUN && $past(genState_reg) == GEN_RUN) |-> genItem_reg >= $past(genItem_reg)) // see R20
        else $error("report restarted before finishing");

    COV_ZERO: cover property (calState_reg == CAL_ZERO ##1 calState_reg == CAL_ANALYZE);
    COV_SPAN: cover property (calState_reg == CAL_SPAN ##1 calState_reg == CAL_ANALYZE);
    COV_REPORT_DONE: cover property (genState_reg == GEN_RUN ##1 genState_reg == GEN_IDLE);
    COV_PAUSE: cover property (cmdPause_reg && clkEn);
endmodule
`default_nettype wire

//--- tb/rcs_term.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// serial terminal at the far end
// ****************************************
module rcs_term #(
    parameter int DIV = 8
) (
    input wire logic clock,
    input wire logic txd,
    output logic rxd
);
    logic [7:0] got[$];
    initial rxd = 1'b1;
    // one 8N1 frame, lsb first; line rests high after stop bit
    task automatic sendByte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clock);
            rxd <= f[i];
            repeat (DIV - 1) @(posedge clock);
        end
    endtask
    // mid-bit sampling; a frame with a bad stop bit is dropped
    always begin
        logic [9:0] f;
        @(negedge txd);
        repeat (DIV / 2) @(posedge clock);
        for (int i = 0; i < 10; i++) begin
            if (i > 0) begin
                repeat (DIV) @(posedge clock);
            end
            f[i] = txd;
        end
        if (f[9] && !f[0]) got.push_back(f[8:1]);
    end
endmodule
`default_nettype wire

//--- tb/test_remote_cal_and_status_port.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// bench for the remote cal and status port
// ****************************************
module test_remote_cal_and_status_port;
    import rcs_pkg::*;
    localparam int BD = 8;
    localparam int RD = 10000;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic clkEn = 1'b1;
    logic zeroReq = 1'b0;
    logic spanReq = 1'b0;
    logic calDone = 1'b0;
    logic [1:0] rangeSel = 2'h0;
    rcs_status_s status = '0;
    logic rxd, txd, calBusy;
    logic [3:0] rangeRelay;
    rcs_valve_s valves;
    logic [15:0] lf = 16'h000F;
    int errCount = 0;
    int nCompared = 0;
    string rng[4] = '{"LO", "MED", "HI", "AIR"};
    string exp;
    always #25 clock = ~clock;
    rcs_port #(.BAUD_DIV(BD), .REPORT_DIV(RD)) dut_u (.clock(clock), .rst_n(rst_n), .clkEn(clkEn),
        .zeroReq(zeroReq), .spanReq(spanReq), .calDone(calDone), .rangeSel(rangeSel), .status(status),
        .rxd(rxd), .txd(txd), .calBusy(calBusy), .rangeRelay(rangeRelay), .valves(valves));
    rcs_term #(.DIV(BD)) term_u (.clock(clock), .txd(txd), .rxd(rxd));
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        nCompared++;
        if (seen !== want) begin
            errCount++;
            $display("wrong value %s expected %0h seen %0h", what, want, seen);
        end
    endtask
    task automatic testDone();
        $display("compared %0d mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // bounded waits; running out ends the run as a mismatch
    task automatic waitFor(input bit bytes, input int n, input int bound);
        for (int i = 0; i < bound; i++) begin
            @(posedge clock);
            #1;
            if (bytes ? term_u.got.size() >= n : calBusy === 1'(n)) return;
        end
        $display("wrong value wait expected %0d seen timeout", n);
        errCount++;
        testDone();
    endtask
    task automatic cmd(input string s);
        for (int i = 0; i < 2; i++) term_u.sendByte(s[i]);
        term_u.sendByte(CHR_CR);
    endtask
    // calibration runs a random while, then the analyzer reports done
    task automatic finishCal();
        lf = lfsr(lf);
        repeat (lf[3:0]) @(posedge clock);
        calDone <= 1'b1;
        @(posedge clock);
        calDone <= 1'b0;
        spanReq <= 1'b0;
        @(posedge clock);
        #1;
        check("calBusy", calBusy, 0);
        check("valves", valves, VALVE_RESET);
    endtask
    // expected report text, item by item, straight from the inputs
    function automatic string expReport(input rcs_status_s s, input int r);
        string t;
        t = $sformatf("%h %s%c%c%s%c%c", s.concBcd, s.unitPct ? "%" : "PPM", CHR_CR, CHR_LF, rng[r], CHR_CR, CHR_LF);
        t = {t, $sformatf("0-%h%c%c", s.spanBcd, CHR_CR, CHR_LF)};
        for (int k = 0; k < NUM_ALARMS; k++) begin
            if (s.alarmOff[k]) t = {t, $sformatf("AL-%0d DISABLED%c%c", k + 1, CHR_CR, CHR_LF)};
        end
        for (int k = 0; k < NUM_ALARMS; k++) begin
            if (s.alarmTrip[k]) t = {t, $sformatf("AL-%0d ON%c%c", k + 1, CHR_CR, CHR_LF)};
        end
        return t;
    endfunction
    initial begin
        for (int i = 0; i < 4; i++) begin
            lf = lfsr(lf);
            status.concBcd[4*i +: 4] = 4'(lf % 10);
            status.spanBcd[4*(i%3) +: 4] = 4'(lf[15:8] % 10);
        end
        status.unitPct = lf[0];
        status.alarmOff = lf[3:2];
        status.alarmTrip = lf[5:4];
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            rangeSel <= 2'(i);
            repeat (2) @(posedge clock);
            #1;
            check("rangeRelay", rangeRelay, 4'h1 << i);
        end
        // a low enable freezes every flop, the relays among them
        @(posedge clock);
        clkEn <= 1'b0;
        rangeSel <= 2'h1;
        repeat (3) @(posedge clock);
        clkEn <= 1'b1;
        rangeSel <= 2'h3;
        #1;
        check("frozen", rangeRelay, 4'h8);
        // zero held until busy closes, span during zero must be forgotten
        @(posedge clock);
        zeroReq <= 1'b1;
        waitFor(0, 1, 4);
        check("valves", valves, 4'h5);
        @(posedge clock);
        zeroReq <= 1'b0;
        spanReq <= 1'b1;
        finishCal();
        repeat (4) @(posedge clock);
        #1;
        check("calBusy", calBusy, 0);
        // span left high past done repeats the calibration
        @(posedge clock);
        spanReq <= 1'b1;
        waitFor(0, 1, 4);
        check("valves", valves, 4'h3);
        calDone <= 1'b1;
        @(posedge clock);
        calDone <= 1'b0;
        #1;
        check("calBusy", calBusy, 0);
        waitFor(0, 1, 3);
        finishCal();
        cmd("ax");
        repeat (4) @(posedge clock);
        #1;
        check("calBusy", calBusy, 0);
        cmd("az");
        waitFor(0, 1, 4);
        check("valves", valves, 4'h5);
        finishCal();
        cmd("as");
        waitFor(0, 1, 4);
        check("valves", valves, 4'h3);
        finishCal();
        // whole first report; pause goes in while it is still being sent
        exp = expReport(status, rangeSel);
        waitFor(1, 1, 2 * RD);
        cmd("st");
        waitFor(1, exp.len(), RD);
        for (int i = 0; i < exp.len(); i++) check("report", term_u.got[i], exp[i]);
        repeat (7000) @(posedge clock);
        term_u.got.delete();
        repeat (2 * RD) @(posedge clock);
        check("paused", term_u.got.size(), 0);
        cmd("st");
        waitFor(1, 1, RD + 8000);
        testDone();
    end
endmodule
`default_nettype wire
